// *** rtl/lcs_consts.vh ***
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH

// System clock
`define LCS_CLK_HZ        25000000
`define LCS_CLK_NS        40

// Line timing, figures in ns at the top rate
`define LCS_BIT_NS        1000
`define LCS_CLR_NS        400
`define LCS_TRANS_NS      200
`define LCS_RXON_NS       750
`define LCS_RXOFF_NS      250
`define LCS_RXCK_NS       250
`define LCS_TMO_NS        1500

// Cycle counts; b is the bit time in ns, all but the clear length scale with it
`define LCS_CLR_CYC       (`LCS_CLR_NS / `LCS_CLK_NS)
`define LCS_HALF_CYC(b)   (((b) / 2) / `LCS_CLK_NS)
`define LCS_TRANS_CYC(b)  ((((b) * `LCS_TRANS_NS) / `LCS_BIT_NS) / `LCS_CLK_NS)
`define LCS_RXON_CYC(b)   ((((b) * `LCS_RXON_NS) / `LCS_BIT_NS) / `LCS_CLK_NS)
`define LCS_RXCK_CYC(b)   ((((b) * `LCS_RXCK_NS) / `LCS_BIT_NS) / `LCS_CLK_NS)
`define LCS_TMO_CYC(b)    ((((b) * `LCS_TMO_NS) / `LCS_BIT_NS) / `LCS_CLK_NS)

// Internal RC source 20 kHz, halved to 10 kHz
`define LCS_RC_HZ         20000
`define LCS_RC_CYC        (`LCS_CLK_HZ / `LCS_RC_HZ)

// Start-up sequence in bit times
`define LCS_CTS_BITS      4'h7
`define LCS_START_BITS    4'h3

// Power-up mark hold
`define LCS_PWRUP_MS      5
`define LCS_PWRUP_CYC     ((`LCS_PWRUP_MS * 1000000) / `LCS_CLK_NS)

// Register offsets
`define LCS_REG_RXCTL     2'h0
`define LCS_REG_TXCTL     2'h1
`define LCS_REG_MODE      2'h2
`define LCS_REG_STAT      2'h3

// Field positions
`define LCS_BIT_LOOP      5
`define LCS_BIT_CLR       7
`define LCS_BIT_RUN       0
`define LCS_BIT_HDX       1
`define LCS_BIT_SREQ      2

// Line levels and reset values
`define LCS_MARK          1'b1
`define LCS_RST_BYTE      8'h00

`endif

// *** rtl/lcs_top.v ***
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "lcs_consts.vh"

module lcs_oneshot
#(
	parameter LEN    = 5,
	parameter RETRIG = 0
)
(
	input  wire clk,
	input  wire reset_n,
	input  wire trig,
	output reg  active
);
	reg [15:0] cnt_r;

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			cnt_r  <= 16'h0000;
			active <= 1'b0;
		end
		else if (trig && (RETRIG != 0 || !active))
		begin
			cnt_r  <= LEN[15:0] - 16'h0001;
			active <= 1'b1;
		end
		else if (active)
		begin
			if (cnt_r == 16'h0000)
				active <= 1'b0;
			else
				cnt_r <= cnt_r - 16'h0001;
		end
	end
endmodule // lcs_oneshot

module lcs_top
#(
	parameter BIT_NS      = `LCS_BIT_NS,
	parameter PWRUP_CYC   = `LCS_PWRUP_CYC
)
(
	input  wire       clk,
	input  wire       reset_n,
	input  wire [1:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr_en,
	input  wire       rd_en,
	output reg  [7:0] rdata,
	input  wire       clear_n,
	input  wire       loopback_request,
	input  wire       step_strobe,
	input  wire       tx_serial_bit,
	input  wire       ext_tx_clk_in,
	input  wire       ext_rx_clk_in,
	input  wire       rx_det_pos,
	input  wire       rx_det_neg,
	output reg        tx_clock,
	output reg        rx_clock,
	output wire       rx_clear_pulse,
	output wire       tx_clear_pulse,
	output reg        internal_square_clock,
	output reg        tx_line,
	output reg        clear_to_send_n,
	output reg        tx_permit,
	output reg        rx_data
);
	localparam HALF_CYC = `LCS_HALF_CYC(BIT_NS);
	localparam TR_CYC   = `LCS_TRANS_CYC(BIT_NS);
	localparam ON_CYC   = `LCS_RXON_CYC(BIT_NS);
	localparam CK_CYC   = `LCS_RXCK_CYC(BIT_NS);
	localparam TMO_CYC  = `LCS_TMO_CYC(BIT_NS);
	localparam RC_CYC   = `LCS_RC_CYC;

	reg  [7:0]  rxctl_r;
	reg  [7:0]  txctl_r;
	reg  [7:0]  mode_r;
	wire        loop_ctl_bit    = rxctl_r[`LCS_BIT_LOOP];
	wire        run_flag        = mode_r[`LCS_BIT_RUN];
	wire        half_duplex_flag = mode_r[`LCS_BIT_HDX];
	wire        send_request_ff = mode_r[`LCS_BIT_SREQ];

	// Register port; an RXCTL or TXCTL write with bit seven low also clears its section
	wire        rx_ctl_select = (addr == `LCS_REG_RXCTL);
	wire        tx_ctl_select = (addr == `LCS_REG_TXCTL);
	wire        alu_bit_seven = wdata[`LCS_BIT_CLR];
	reg  [7:0]  stat_w;

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			rxctl_r <= `LCS_RST_BYTE;
			txctl_r <= `LCS_RST_BYTE;
			mode_r  <= `LCS_RST_BYTE;
			rdata   <= 8'h00;
		end
		else
		begin
			if (wr_en && rx_ctl_select)
				rxctl_r <= wdata;
			if (wr_en && tx_ctl_select)
				txctl_r <= wdata;
			if (wr_en && addr == `LCS_REG_MODE)
				mode_r <= wdata;
			if (rd_en)
			begin
				case (addr)
				`LCS_REG_RXCTL: rdata <= rxctl_r;
				`LCS_REG_TXCTL: rdata <= txctl_r;
				`LCS_REG_MODE:  rdata <= mode_r;
				default:        rdata <= stat_w;
				endcase
			end
			else
				rdata <= 8'h00;
		end
	end

	// Clear generators: trigger level falls on a clear request
	reg         rx_trig_d_r;
	reg         tx_trig_d_r;
	wire        rx_trig_lvl = ~(~clear_n | (wr_en & rx_ctl_select & ~alu_bit_seven));
	wire        tx_trig_lvl = ~(~clear_n | (wr_en & tx_ctl_select & ~alu_bit_seven));

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			rx_trig_d_r <= 1'b1;
			tx_trig_d_r <= 1'b1;
		end
		else
		begin
			rx_trig_d_r <= rx_trig_lvl;
			tx_trig_d_r <= tx_trig_lvl;
		end
	end

	lcs_oneshot #(.LEN(`LCS_CLR_CYC), .RETRIG(0)) u_rx_clr
	(
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (rx_trig_d_r & ~rx_trig_lvl),
		.active  (rx_clear_pulse)
	);

	lcs_oneshot #(.LEN(`LCS_CLR_CYC), .RETRIG(0)) u_tx_clr
	(
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (tx_trig_d_r & ~tx_trig_lvl),
		.active  (tx_clear_pulse)
	);

	// Internal square clock: 20 kHz tick, halved
	reg  [15:0] rc_cnt_r;

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			rc_cnt_r              <= 16'h0000;
			internal_square_clock <= 1'b0;
		end
		else if (rc_cnt_r == RC_CYC[15:0] - 16'h0001)
		begin
			rc_cnt_r              <= 16'h0000;
			internal_square_clock <= ~internal_square_clock;
		end
		else
			rc_cnt_r <= rc_cnt_r + 16'h0001;
	end

	// Pin inputs, two flip-flops before use
	// Not reset: they fill with the pin levels during reset, so no false edge follows it
	reg  [1:0]  etx_s_r;
	reg  [1:0]  erx_s_r;
	reg  [1:0]  dpos_s_r;
	reg  [1:0]  dneg_s_r;

	always @(posedge clk)
	begin
		etx_s_r  <= {etx_s_r[0], ext_tx_clk_in};
		erx_s_r  <= {erx_s_r[0], ext_rx_clk_in};
		dpos_s_r <= {dpos_s_r[0], rx_det_pos};
		dneg_s_r <= {dneg_s_r[0], rx_det_neg};
	end

	// Modem transmitter; bit time is 2*HALF_CYC, so 24 cycles at 1 Mbps
	// (about 4 percent fast, inside the oscillator tolerance)
	reg  [7:0]  osc_cnt_r;
	reg         bit_phase_r;
	reg         data_ff_r;
	reg         out_ff_r;
	reg         rts_ff_r;
	reg  [3:0]  bit_cnt_r;
	reg         enable_r;
	reg  [19:0] pwr_cnt_r;
	reg         pwr_ok_r;
	wire        osc_tick  = (osc_cnt_r == HALF_CYC[7:0] - 8'h01);
	wire        bit_start = osc_tick & ~bit_phase_r;
	wire        mid_bit   = osc_tick & bit_phase_r;

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			osc_cnt_r   <= 8'h00;
			bit_phase_r <= 1'b0;
			data_ff_r   <= 1'b0;
			out_ff_r    <= 1'b0;
		end
		else
		begin
			osc_cnt_r <= osc_tick ? 8'h00 : osc_cnt_r + 8'h01;
			if (osc_tick)
				bit_phase_r <= ~bit_phase_r;
			if (bit_start)
				data_ff_r <= ~tx_serial_bit;
			// Boundary pulse always; mid-bit pulse only for a space
			// Data ff holds the inverted bit, so it is high for a space
			if (bit_start || (mid_bit && data_ff_r))
				out_ff_r <= ~out_ff_r;
		end
	end

	// Request, clear-to-send delay and enable sequencing
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			rts_ff_r        <= 1'b0;
			bit_cnt_r       <= 4'h0;
			clear_to_send_n <= 1'b1;
			tx_permit       <= 1'b0;
			enable_r        <= 1'b0;
		end
		else if (!send_request_ff)
		begin
			rts_ff_r        <= 1'b0;
			bit_cnt_r       <= 4'h0;
			clear_to_send_n <= 1'b1;
			tx_permit       <= 1'b0;
			enable_r        <= 1'b0;
		end
		else
		begin
			rts_ff_r <= 1'b1;
			if (rts_ff_r && bit_start && bit_cnt_r != `LCS_CTS_BITS + `LCS_START_BITS)
				bit_cnt_r <= bit_cnt_r + 4'h1;
			if (bit_cnt_r == `LCS_CTS_BITS)
			begin
				clear_to_send_n <= 1'b0;
				tx_permit       <= 1'b1;
			end
			if (bit_cnt_r == `LCS_CTS_BITS + `LCS_START_BITS)
				enable_r <= 1'b1;
		end
	end

	// Power-up mark hold; the count is a parameter for short simulations
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			pwr_cnt_r <= 20'h00000;
			pwr_ok_r  <= 1'b0;
		end
		else if (!pwr_ok_r)
		begin
			if (pwr_cnt_r == PWRUP_CYC[19:0] - 20'h00001)
				pwr_ok_r <= 1'b1;
			else
				pwr_cnt_r <= pwr_cnt_r + 20'h00001;
		end
	end

	always @(posedge clk)
	begin
		if (!reset_n)
			tx_line <= `LCS_MARK;
		else if (enable_r && pwr_ok_r && !clear_to_send_n && send_request_ff)
			tx_line <= out_ff_r;
		else
			tx_line <= `LCS_MARK;
	end

	// Modem receiver
	reg         pos_d_r;
	reg         neg_d_r;
	wire        pos_pls;
	wire        neg_pls;
	reg         comb_d_r;
	wire        comb_pls = pos_pls | neg_pls;
	wire        comb_rise = comb_pls & ~comb_d_r;
	wire        on_pls;
	reg         on_d_r;
	wire        ck_pls;
	wire        tmo_act;
	reg         mid_seen_r;

	always @(posedge clk)
	begin
		pos_d_r <= dpos_s_r[1];
		neg_d_r <= dneg_s_r[1];
		if (!reset_n)
		begin
			comb_d_r <= 1'b0;
			on_d_r   <= 1'b0;
		end
		else
		begin
			comb_d_r <= comb_pls;
			on_d_r   <= on_pls;
		end
	end

	lcs_oneshot #(.LEN(TR_CYC), .RETRIG(0)) u_pos
	(
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (dpos_s_r[1] & ~pos_d_r),
		.active  (pos_pls)
	);

	lcs_oneshot #(.LEN(TR_CYC), .RETRIG(0)) u_neg
	(
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (dneg_s_r[1] & ~neg_d_r),
		.active  (neg_pls)
	);

	lcs_oneshot #(.LEN(ON_CYC), .RETRIG(0)) u_on
	(
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (comb_rise),
		.active  (on_pls)
	);

	lcs_oneshot #(.LEN(CK_CYC), .RETRIG(0)) u_ck
	(
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (comb_rise & ~on_pls),
		.active  (ck_pls)
	);

	lcs_oneshot #(.LEN(TMO_CYC), .RETRIG(1)) u_tmo
	(
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (on_pls & ~on_d_r),
		.active  (tmo_act)
	);

	// A transition inside the on window (on_pls) marks a space
	always @(posedge clk)
	begin
		if (!reset_n || !tmo_act)
		begin
			mid_seen_r <= 1'b0;
			rx_data    <= 1'b0;
		end
		else
		begin
			if (on_pls && comb_rise)
				mid_seen_r <= 1'b1;
			else if (on_d_r && !on_pls)
				mid_seen_r <= 1'b0;
			if (on_d_r && !on_pls)
				rx_data <= ~mid_seen_r;
		end
	end

	// Clock source selector
	reg         step_clk_r;
	wire        sel_lo = loopback_request | loop_ctl_bit;
	wire        sel_hi = run_flag;
	reg         tx_src;
	reg         rx_src;

	always @*
	begin
		case ({sel_hi, sel_lo})
		2'b00:
		begin
			tx_src = bit_phase_r;
			rx_src = ck_pls;
		end
		2'b01:
		begin
			tx_src = step_clk_r;
			rx_src = step_clk_r;
		end
		2'b10:
		begin
			tx_src = etx_s_r[1];
			rx_src = erx_s_r[1];
		end
		default:
		begin
			tx_src = internal_square_clock;
			rx_src = internal_square_clock;
		end
		endcase
	end

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			step_clk_r <= 1'b0;
			tx_clock   <= 1'b0;
			rx_clock   <= 1'b0;
		end
		else
		begin
			step_clk_r <= step_strobe;
			tx_clock   <= tx_src;
			rx_clock   <= rx_src & ~(half_duplex_flag & send_request_ff);
		end
	end

	always @*
	begin
		stat_w = {rx_data, tmo_act, pwr_ok_r, enable_r, tx_permit,
			rts_ff_r, sel_hi, sel_lo};
	end
endmodule // lcs_top
`default_nettype wire

// *** bench/lcs_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcs_checker
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       clear_n,
	input wire logic       rx_clear_pulse,
	input wire logic       tx_clear_pulse,
	input wire logic       internal_square_clock,
	input wire logic       tx_line,
	input wire logic       clear_to_send_n,
	input wire logic       tx_permit
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Cycles since the square clock last moved
	logic [11:0] sq_cnt_r;
	logic        sq_old_r;
	always @(posedge clk)
	begin
		sq_old_r <= internal_square_clock;
		if (!reset_n || sq_old_r != internal_square_clock)
			sq_cnt_r <= 12'h000;
		else
			sq_cnt_r <= sq_cnt_r + 12'h001;
	end
	rx_clr_len_a: assert property (
		$rose(rx_clear_pulse) |-> rx_clear_pulse[*8] ##1 rx_clear_pulse[*2] ##1 !rx_clear_pulse)
		else $error("rx clear pulse length");
	tx_clr_len_a: assert property (
		$rose(tx_clear_pulse) |-> tx_clear_pulse[*8] ##1 tx_clear_pulse[*2] ##1 !tx_clear_pulse)
		else $error("tx clear pulse length");
	both_clear_a: assert property (
		$fell(clear_n) |-> ##2 rx_clear_pulse && tx_clear_pulse)
		else $error("global clear missed a section");
	rx_sect_clr_a: assert property (
		wr_en && addr == 2'h0 && !wdata[7] && clear_n |-> ##2 rx_clear_pulse && !$rose(tx_clear_pulse))
		else $error("rx section clear wrong");
	tx_sect_clr_a: assert property (
		wr_en && addr == 2'h1 && !wdata[7] && clear_n |-> ##2 tx_clear_pulse && !$rose(rx_clear_pulse))
		else $error("tx section clear wrong");
	cts_permit_a: assert property (
		tx_permit != clear_to_send_n)
		else $error("permit and clear to send disagree");
	mark_hold_a: assert property (
		!tx_permit |-> tx_line)
		else $error("line left mark without permit");
	pwrup_mark_a: assert property (
		$rose(reset_n) |-> tx_line[*8])
		else $error("line not mark after reset");
	line_gap_a: assert property (
		$changed(tx_line) ##[10:26] $changed(tx_line) |=> ($stable(tx_line) || !tx_permit)[*8])
		else $error("line toggles too close");
	sq_period_a: assert property (
		$changed(internal_square_clock) |-> sq_cnt_r >= 12'h4dd && sq_cnt_r <= 12'h4e4)
		else $error("square clock half period wrong");
endmodule // lcs_checker
bind lcs_top lcs_checker chk_i (.*);
`default_nettype wire

// *** bench/lcs_far_station.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcs_far_station
#(
	parameter int BIT_T = 960
)
(
	output wire logic rx_det_pos,
	output wire logic rx_det_neg
);
	// Line just holds between frames, so no transitions reach the receiver
	logic lvl_r = 1'h0;
	assign rx_det_pos = lvl_r;
	assign rx_det_neg = ~lvl_r;
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			lvl_r = ~lvl_r;
			#(BIT_T / 2);
			if (!b[i])
				lvl_r = ~lvl_r;
			#(BIT_T / 2);
		end
	endtask
endmodule // lcs_far_station
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int PW = 400;
	logic       clk = 1'h0;
	logic       reset_n = 1'h0;
	logic       wr_en = 1'h0;
	logic       rd_en = 1'h0;
	logic       clear_n = 1'h1;
	logic       loopback_request = 1'h0;
	logic       step_strobe = 1'h0;
	logic       tx_serial_bit = 1'h1;
	logic       lclk = 1'h0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] d;
	wire  [7:0] rdata;
	wire        ext_tx_clk_in = lclk;
	wire        ext_rx_clk_in = lclk;
	wire        rx_det_pos, rx_det_neg, tx_clock, rx_clock, rx_clear_pulse, tx_clear_pulse;
	wire        internal_square_clock, tx_line, clear_to_send_n, tx_permit, rx_data;
	int         n_fail = 0;
	int         comparisons = 0;
	int         p, t, r;
	lcs_top #(.PWRUP_CYC(PW)) DUT (.*);
	lcs_far_station #(.BIT_T(960)) far (.*);
	always #20 clk = ~clk;
	// Link clock phase kept apart from clk
	initial
	begin
		#7;
		forever #160 lclk = ~lclk;
	end
	task finish_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task in_rng(input int v, input int lo, input int hi);
		chk(16'(v), (v >= lo && v <= hi) ? 16'(v) : 16'(lo));
	endtask
	task tick(inout int n);
		@(posedge clk);
		#1;
		n++;
		if (n > 4000)
		begin
			chk(16'h0, 16'h1);
			finish_test;
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask
	task rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		#1;
		v = rdata;
	endtask
	task wtog(output int g);
		logic v;
		g = 0;
		v = tx_line;
		while (tx_line === v)
			tick(g);
	endtask
	task rises(input int n, output int tr, output int rr);
		logic pt, pr;
		tr = 0;
		rr = 0;
		repeat (n)
		begin
			pt = tx_clock;
			pr = rx_clock;
			@(posedge clk);
			#1;
			tr += int'(tx_clock & !pt);
			rr += int'(rx_clock & !pr);
		end
	endtask
	task tx_start;
		p = 0;
		wr(2'h2, 8'h04);
		while (tx_permit !== 1'h1)
			tick(p);
		wtog(t);
	endtask
	task rx_byte(input logic [7:0] b, input int er);
		@(posedge clk);
		#5;
		fork
			far.send(b);
			rises(240, t, r);
			begin
				#1360;
				for (int i = 0; i < 8; i++)
				begin
					chk(16'(rx_data), 16'(b[i]));
					#960;
				end
			end
		join
		chk(16'(r), 16'(er));
		chk(16'(rx_data), 16'h0);
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		reset_n <= 1'h1;
		rd(2'h3, d);
		chk(d, 8'h00);
		tx_start;
		in_rng(p + t, PW - 8, PW + 60);
		in_rng(p, 140, 175);
		wr(2'h2, 8'h00);
		tx_start;
		in_rng(p, 140, 175);
		in_rng(t, 46, 100);
		wtog(t);
		wtog(t);
		chk(16'(t), 16'h18);
		@(posedge clk);
		tx_serial_bit <= 1'h0;
		repeat (5) wtog(t);
		chk(16'(t), 16'h0c);
		$display("transmit test done");
		wr(2'h2, 8'h00);
		wr(2'h0, 8'h00);
		tick(p);
		chk({rx_clear_pulse, tx_clear_pulse}, 16'h2);
		repeat (12) @(posedge clk);
		wr(2'h1, 8'h00);
		tick(p);
		chk({rx_clear_pulse, tx_clear_pulse}, 16'h1);
		repeat (12) @(posedge clk);
		clear_n <= 1'h0;
		@(posedge clk);
		clear_n <= 1'h1;
		tick(p);
		chk({rx_clear_pulse, tx_clear_pulse}, 16'h3);
		$display("clear test done");
		wr(2'h0, 8'ha0);
		rd(2'h3, d);
		chk(d & 8'h03, 8'h01);
		@(posedge clk);
		step_strobe <= 1'h1;
		@(posedge clk);
		step_strobe <= 1'h0;
		rises(10, t, r);
		chk(16'(t + r), 16'h2);
		wr(2'h0, 8'h80);
		@(posedge clk);
		loopback_request <= 1'h1;
		wr(2'h2, 8'h01);
		rd(2'h3, d);
		chk(d & 8'h03, 8'h03);
		rises(2600, t, r);
		in_rng(t, 1, 2);
		@(posedge clk);
		loopback_request <= 1'h0;
		rises(80, t, r);
		in_rng(t, 9, 11);
		wr(2'h3, 8'hff);
		rd(2'h2, d);
		chk(d, 8'h01);
		wr(2'h2, 8'h00);
		repeat (2) @(posedge clk);
		rises(96, t, r);
		chk(16'(t), 16'h4);
		$display("selector test done");
		rx_byte(8'ha5, 8);
		wr(2'h2, 8'h06);
		rx_byte(8'h3c, 0);
		$display("receive test done");
		finish_test;
	end
endmodule // tb
`default_nettype wire
